// *** crf_rx_filter.v ***
// Design decisions made here: the APB slave port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
`include "crf_consts.vh"

module crf_rx_filter (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        rx_valid,
  input  wire [10:0] standard_id_bits,
  input  wire [17:0] extended_id_bits,
  input  wire        rx_ide,
  input  wire        rx_rtr,
  input  wire [3:0]  rx_dlc,
  input  wire [63:0] rx_data,
  input  wire [15:0] rx_stamp,
  output reg         store_valid,
  output reg  [5:0]  match_index_field,
  output reg  [31:0] store_id,
  output reg  [3:0]  store_dlc,
  output reg  [63:0] store_data,
  output reg  [15:0] store_stamp,
  output reg         drop_pulse
);

  // ----------------------------------------------------------------
  // state codes
  // ----------------------------------------------------------------
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LIST = 2'h1;
  localparam [1:0] ST_MASK = 2'h2;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [31:0] bank_filter_byte [0:15];
  reg [31:0] bank_config_reg;
  reg [31:0] bank_mode_reg;
  reg [1:0]  state;
  reg [31:0] id_hold;
  reg [3:0]  dlc_hold;
  reg [63:0] data_hold;
  reg [15:0] stamp_hold;
  reg [15:0] accept_count;
  reg        last_ok;

  wire [63:0]  ent_exist;
  wire [63:0]  ent_hit;
  wire [63:0]  ent_list;
  wire [127:0] ent_cov;
  wire         pick_found;
  wire [5:0]   pick_index;

  // identifier packed the way filter bytes are laid out: byte 0 low
  wire [31:0] id_word = {extended_id_bits[6:0], 1'b0,
                         extended_id_bits[14:7],
                         standard_id_bits[2:0], rx_rtr, rx_ide, extended_id_bits[17:15],
                         standard_id_bits[10:3]};

  // ----------------------------------------------------------------
  // bank compare
  // ----------------------------------------------------------------
  genvar b;
  generate
    for (b = 0; b < 8; b = b + 1) begin : g_bank
      crf_bank_match u_bank (
        .bank_bytes          ({bank_filter_byte[2*b+1], bank_filter_byte[2*b]}),
        .bank_scale_select   (bank_config_reg[`CRF_CFG_STRIDE*b+1:`CRF_CFG_STRIDE*b]),
        .low_half_list_mode  (bank_mode_reg[b]),
        .high_half_list_mode (bank_mode_reg[`CRF_MODE_HIGH+b]),
        .bank_active         (bank_config_reg[`CRF_CFG_STRIDE*b+`CRF_CFG_ACTIVE]),
        .id_word             (id_hold),
        .ent_exist           (ent_exist[8*b+7:8*b]),
        .ent_hit             (ent_hit[8*b+7:8*b]),
        .ent_list            (ent_list[8*b+7:8*b]),
        .ent_cov             (ent_cov[16*b+15:16*b])
      );
    end
  endgenerate

  // one picker serves both passes; the pass selects which mode it sees
  crf_winner_pick u_pick (
    .ent_exist (ent_exist),
    .ent_hit   (ent_hit),
    .ent_list  (ent_list),
    .ent_cov   (ent_cov),
    .want_list (state == ST_LIST),
    .found     (pick_found),
    .index     (pick_index)
  );

  // ----------------------------------------------------------------
  // apb slave: one wait state, so pready and prdata come from flops
  // ----------------------------------------------------------------
  wire acc_go  = psel & penable & ~pready;
  wire wr_done = psel & penable & pready & pwrite & ~pslverr;
  wire in_filt = (paddr[7:6] == 2'h0);
  wire aligned = (paddr[1:0] == 2'h0);

  reg [31:0] next_rdata;
  reg        next_err;

  always @* begin
    next_rdata = 32'h0;
    next_err = 1'b0;
    if (!aligned) begin
      next_err = 1'b1;
    end else if (in_filt) begin
      next_rdata = bank_filter_byte[paddr[5:2]];
    end else if (paddr == `CRF_CONFIG_OFS) begin
      next_rdata = bank_config_reg;
    end else if (paddr == `CRF_MODE_OFS) begin
      next_rdata = bank_mode_reg;
    end else if (paddr == `CRF_STATUS_OFS) begin
      next_rdata = {accept_count, 6'h0, state, 1'b0, last_ok, match_index_field};
    end else begin
      next_err = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= acc_go;
      prdata <= (acc_go && !pwrite) ? next_rdata : 32'h0;
      pslverr <= acc_go & next_err;
    end
  end

  // config writes are not locked while a bank is active; software
  // must take the bank out of service first
  integer i;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 16; i = i + 1) begin
        bank_filter_byte[i] <= `CRF_FILT_RST;
      end
      bank_config_reg <= `CRF_CONFIG_RST;
      bank_mode_reg <= `CRF_MODE_RST;
    end else if (wr_done) begin
      if (in_filt) begin
        bank_filter_byte[paddr[5:2]] <= pwdata;
      end else if (paddr == `CRF_CONFIG_OFS) begin
        bank_config_reg <= pwdata & 32'h7777_7777;
      end else if (paddr == `CRF_MODE_OFS) begin
        bank_mode_reg <= {16'h0, pwdata[15:0]};
      end
    end
  end

  // ----------------------------------------------------------------
  // acceptance sequence: list pass, then mask pass
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      id_hold <= 32'h0;
      dlc_hold <= 4'h0;
      data_hold <= 64'h0;
      stamp_hold <= 16'h0;
      store_valid <= 1'b0;
      match_index_field <= 6'h0;
      store_id <= 32'h0;
      store_dlc <= 4'h0;
      store_data <= 64'h0;
      store_stamp <= 16'h0;
      drop_pulse <= 1'b0;
      accept_count <= 16'h0;
      last_ok <= 1'b0;
    end else begin
      store_valid <= 1'b0;
      drop_pulse <= 1'b0;
      case (state)
        ST_IDLE: begin
          // frames arrive far apart; a new one during a pass is ignored
          if (rx_valid) begin
            id_hold <= id_word;
            dlc_hold <= rx_dlc;
            data_hold <= rx_data;
            stamp_hold <= rx_stamp;
            state <= ST_LIST;
          end
        end
        ST_LIST: begin
          if (pick_found) begin
            store_valid <= 1'b1;
            match_index_field <= pick_index;
            store_id <= id_hold;
            store_dlc <= dlc_hold;
            store_data <= data_hold;
            store_stamp <= stamp_hold;
            accept_count <= accept_count + 16'h1;
            last_ok <= 1'b1;
            state <= ST_IDLE;
          end else begin
            state <= ST_MASK;
          end
        end
        ST_MASK: begin
          if (pick_found) begin
            store_valid <= 1'b1;
            match_index_field <= pick_index;
            store_id <= id_hold;
            store_dlc <= dlc_hold;
            store_data <= data_hold;
            store_stamp <= stamp_hold;
            accept_count <= accept_count + 16'h1;
            last_ok <= 1'b1;
          end else begin
            drop_pulse <= 1'b1;
            last_ok <= 1'b0;
          end
          state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // crf_rx_filter
`default_nettype wire

// *** crf_consts.vh ***
// Overview of operation
// - two-bit scale field picks bank filter split
// - 32-bit scale: identifier bytes 0-3, mask 4-7
// - low/high mode bits govern low/high byte pairs
// - 16-bit scale: low bit bytes 2-3, high 6-7
// - 8-bit scale: low bit bytes 1,3; high 5,7
// - 8-bit filters compare standard bits 10..3 only
// - mixed scale: one 16-bit, two 8-bit filters
// - mask bit set means must match
// - list mode: match either identifier exactly
// - accepted message carries its filter match index
// - list-mode filter beats mask-mode filter
// - wider coverage wins within same mode
// - then lower bank, lower register wins
// - list-mode filters checked first, hit stores
// - mask filters checked only without list hit
// - unmatched message dropped silently
// - stored message keeps id, data, control, stamp
`ifndef CRF_CONSTS_VH
`define CRF_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CRF_FILT_BASE    8'h00
`define CRF_CONFIG_OFS   8'h40
`define CRF_MODE_OFS     8'h44
`define CRF_STATUS_OFS   8'h48

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define CRF_CFG_STRIDE   4
`define CRF_CFG_ACTIVE   2
`define CRF_MODE_HIGH    8
`define CRF_CONFIG_RST   32'h0000_0000
`define CRF_MODE_RST     32'h0000_0000
`define CRF_FILT_RST     32'h0000_0000

// ----------------------------------------------------------------
// scale codes and compare widths
// ----------------------------------------------------------------
`define CRF_SCALE_32     2'h3
`define CRF_SCALE_16     2'h2
`define CRF_SCALE_MIX    2'h1
`define CRF_SCALE_8      2'h0
`define CRF_WIDTH_32     32'hfeff_ffff
`define CRF_WIDTH_16     32'h0000_ffff
`define CRF_WIDTH_8      32'h0000_00ff
`define CRF_COV_32       2'h2
`define CRF_COV_16       2'h1
`define CRF_COV_8        2'h0

`endif

// *** crf_bank_match.v ***
`timescale 1ns/100ps
`default_nettype none
`include "crf_consts.vh"

module crf_bank_match (
  input  wire [63:0] bank_bytes,
  input  wire [1:0]  bank_scale_select,
  input  wire        low_half_list_mode,
  input  wire        high_half_list_mode,
  input  wire        bank_active,
  input  wire [31:0] id_word,
  output wire [7:0]  ent_exist,
  output wire [7:0]  ent_hit,
  output wire [7:0]  ent_list,
  output wire [15:0] ent_cov
);

  reg [127:0] fx;
  reg [127:0] fy;
  reg [127:0] fw;
  reg [3:0]   fe;
  reg [3:0]   fl;
  reg [7:0]   fc;

  wire [31:0] lo = bank_bytes[31:0];
  wire [31:0] hi = bank_bytes[63:32];

  // ----------------------------------------------------------------
  // filter layout per scale
  // ----------------------------------------------------------------
  always @* begin
    fx = 128'h0;
    fy = 128'h0;
    fw = 128'h0;
    fe = 4'h0;
    fl = 4'h0;
    fc = 8'h0;
    case (bank_scale_select)
      `CRF_SCALE_32: begin
        // low bit chosen; both bits are expected equal here
        fx[31:0] = lo;
        fy[31:0] = hi;
        fw[31:0] = `CRF_WIDTH_32;
        fe = 4'h1;
        fl[0] = low_half_list_mode;
        fc[1:0] = `CRF_COV_32;
      end
      `CRF_SCALE_16: begin
        fx[31:0] = {16'h0, lo[15:0]};
        fy[31:0] = {16'h0, lo[31:16]};
        fx[63:32] = {16'h0, hi[15:0]};
        fy[63:32] = {16'h0, hi[31:16]};
        fw[63:0] = {2{`CRF_WIDTH_16}};
        fe = 4'h3;
        fl[1:0] = {high_half_list_mode, low_half_list_mode};
        fc[3:0] = {`CRF_COV_16, `CRF_COV_16};
      end
      `CRF_SCALE_MIX: begin
        fx[31:0] = {16'h0, lo[15:0]};
        fy[31:0] = {16'h0, lo[31:16]};
        fx[63:32] = {24'h0, hi[7:0]};
        fy[63:32] = {24'h0, hi[15:8]};
        fx[95:64] = {24'h0, hi[23:16]};
        fy[95:64] = {24'h0, hi[31:24]};
        fw[95:0] = {`CRF_WIDTH_8, `CRF_WIDTH_8, `CRF_WIDTH_16};
        fe = 4'h7;
        fl[2:0] = {high_half_list_mode, high_half_list_mode, low_half_list_mode};
        fc[5:0] = {`CRF_COV_8, `CRF_COV_8, `CRF_COV_16};
      end
      default: begin
        fx = {24'h0, hi[23:16], 24'h0, hi[7:0], 24'h0, lo[23:16], 24'h0, lo[7:0]};
        fy = {24'h0, hi[31:24], 24'h0, hi[15:8], 24'h0, lo[31:24], 24'h0, lo[15:8]};
        fw = {4{`CRF_WIDTH_8}};
        fe = 4'hf;
        fl = {high_half_list_mode, high_half_list_mode, low_half_list_mode, low_half_list_mode};
        fc = {4{`CRF_COV_8}};
      end
    endcase
  end

  // ----------------------------------------------------------------
  // per-filter compare; list mode yields two identifier entries
  // ----------------------------------------------------------------
  genvar j;
  generate
    for (j = 0; j < 4; j = j + 1) begin : g_filt
      wire [31:0] x = fx[32*j+31:32*j];
      wire [31:0] y = fy[32*j+31:32*j];
      wire [31:0] w = fw[32*j+31:32*j];
      wire mask_hit = (((id_word ^ x) & y & w) == 32'h0);
      wire id0_hit  = (((id_word ^ x) & w) == 32'h0);
      wire id1_hit  = (((id_word ^ y) & w) == 32'h0);
      assign ent_exist[2*j]   = fe[j];
      assign ent_exist[2*j+1] = fe[j] & fl[j];
      assign ent_hit[2*j]     = bank_active & fe[j] & (fl[j] ? id0_hit : mask_hit);
      assign ent_hit[2*j+1]   = bank_active & fe[j] & fl[j] & id1_hit;
      assign ent_list[2*j]    = fl[j];
      assign ent_list[2*j+1]  = fl[j];
      assign ent_cov[4*j+1:4*j]   = fc[2*j+1:2*j];
      assign ent_cov[4*j+3:4*j+2] = fc[2*j+1:2*j];
    end
  endgenerate

endmodule // crf_bank_match
`default_nettype wire

// *** crf_winner_pick.v ***
`timescale 1ns/100ps
`default_nettype none

module crf_winner_pick (
  input  wire [63:0]  ent_exist,
  input  wire [63:0]  ent_hit,
  input  wire [63:0]  ent_list,
  input  wire [127:0] ent_cov,
  input  wire         want_list,
  output reg          found,
  output reg  [5:0]   index
);

  integer     k;
  reg [6:0]   cnt;
  reg [1:0]   best_cov;

  // ----------------------------------------------------------------
  // scan in filter order; only a strictly wider filter displaces
  // an earlier winner, so ties keep the lowest number
  // ----------------------------------------------------------------
  always @* begin
    found = 1'b0;
    index = 6'h0;
    cnt = 7'h0;
    best_cov = 2'h0;
    for (k = 0; k < 64; k = k + 1) begin
      if (ent_hit[k] && (ent_list[k] == want_list) &&
          (!found || (ent_cov[2*k+:2] > best_cov))) begin
        found = 1'b1;
        best_cov = ent_cov[2*k+:2];
        index = cnt[5:0];
      end
      cnt = cnt + {6'h0, ent_exist[k]};
    end
  end

endmodule // crf_winner_pick
`default_nettype wire

// *** crf_rx_filter_props.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// port checker for the receive filter
// ----------------------------------------------------------------
module crf_rx_filter_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        rx_valid,
  input wire logic        store_valid,
  input wire logic [5:0]  match_index_field,
  input wire logic [15:0] store_stamp,
  input wire logic        drop_pulse
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // list pass answers one cycle before the mask pass
  sequence list_hit;
    ##2 store_valid;
  endsequence
  sequence mask_end;
    ##3 (store_valid || drop_pulse);
  endsequence
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("pready missing after one wait state");
  apb_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("pready outside access or too long");
  apb_map_a: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > 8'h48))
    else $error("pslverr does not follow the address map");
  read_idle_a: assert property (!pready || pslverr |-> prdata == 32'h0)
    else $error("prdata nonzero outside a good read");
  rx_answer_a: assert property (rx_valid |-> list_hit or mask_end)
    else $error("frame not answered in time");
  store_cause_a: assert property (store_valid |-> $past(rx_valid, 2) || $past(rx_valid, 3))
    else $error("store without a frame");
  drop_cause_a: assert property (drop_pulse |-> $past(rx_valid, 3) && !store_valid)
    else $error("drop without a frame");
  index_hold_a: assert property ($changed(match_index_field) |-> store_valid)
    else $error("match index moved without a store");
  stamp_hold_a: assert property ($changed(store_stamp) |-> store_valid)
    else $error("stamp moved without a store");
endmodule // crf_rx_filter_chk
bind crf_rx_filter crf_rx_filter_chk u_chk (.pclk, .presetn, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .rx_valid, .store_valid, .match_index_field, .store_stamp, .drop_pulse);
`default_nettype wire

// *** crf_rx_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// receive path and fifo side model
// ----------------------------------------------------------------
module crf_rx_model (
  input  wire logic        pclk,
  output var  logic        rx_valid,
  output var  logic [10:0] standard_id_bits,
  output var  logic [17:0] extended_id_bits,
  output var  logic        rx_ide,
  output var  logic        rx_rtr,
  output var  logic [3:0]  rx_dlc,
  output var  logic [63:0] rx_data,
  output var  logic [15:0] rx_stamp,
  input  wire logic        store_valid,
  input  wire logic        drop_pulse,
  input  wire logic [5:0]  match_index_field
);
  initial begin
    rx_valid = 1'h0;
    {standard_id_bits, extended_id_bits, rx_ide, rx_rtr} = 31'h0;
    {rx_dlc, rx_data, rx_stamp} = 84'h0;
  end
  task automatic send(input logic [10:0] s, input logic [17:0] e, input logic ide,
                      output int lat, output logic got, output logic [5:0] idx);
    @(posedge pclk);
    rx_valid         <= 1'h1;
    standard_id_bits <= s;
    extended_id_bits <= e;
    rx_ide           <= ide;
    rx_rtr           <= s[0];
    rx_dlc           <= 4'h8;
    rx_data          <= {e[15:0], {3{5'h00, s}}};
    rx_stamp         <= {5'h00, s};
    @(posedge pclk);
    // fields mean nothing after the strobe, so do not leave them looking valid
    rx_valid         <= 1'h0;
    {standard_id_bits, extended_id_bits, rx_ide, rx_rtr} <= ~{s, e, ide, s[0]};
    {rx_dlc, rx_data, rx_stamp} <= ~{rx_dlc, rx_data, rx_stamp};
    lat = 0;
    while (lat < 6 && store_valid !== 1'h1 && drop_pulse !== 1'h1) begin
      @(negedge pclk);
      lat++;
    end
    got = store_valid;
    idx = match_index_field;
  endtask
endmodule // crf_rx_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, store_id, rd, p;
  logic        rx_valid, rx_ide, rx_rtr, store_valid, drop_pulse;
  logic [10:0] standard_id_bits;
  logic [17:0] extended_id_bits;
  logic [3:0]  rx_dlc, store_dlc;
  logic [63:0] rx_data, store_data;
  logic [15:0] rx_stamp, store_stamp;
  logic [5:0]  match_index_field;
  int          fails, n_checks, cyc;
  crf_rx_filter i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rx_valid, .standard_id_bits, .extended_id_bits, .rx_ide, .rx_rtr,
    .rx_dlc, .rx_data, .rx_stamp, .store_valid, .match_index_field, .store_id, .store_dlc,
    .store_data, .store_stamp, .drop_pulse);
  crf_rx_model i_rx (.pclk, .rx_valid, .standard_id_bits, .extended_id_bits, .rx_ide, .rx_rtr,
    .rx_dlc, .rx_data, .rx_stamp, .store_valid, .drop_pulse, .match_index_field);
  // ----------------------------------------------------------------
  // clock, timeout and helpers
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'h0;
    forever #12.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      fails++;
      final_report;
    end
  end
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  function automatic logic [31:0] pk(input logic [10:0] s, input logic [17:0] e, input logic i);
    return {e[6:0], 1'h0, e[14:7], s[2:0], s[0], i, e[17:15], s[10:3]};
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'h1, 1'h0, w, a, d};
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic fr(input logic [10:0] s, input logic [17:0] e, input logic i, input int el,
                    input logic eg, input logic [5:0] ei);
    int         lat;
    logic       got;
    logic [5:0] idx;
    i_rx.send(s, e, i, lat, got, idx);
    check("latency", lat, el);
    check("accepted", got, eg);
    check("match index", eg ? idx : 6'h00, ei);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    apb(1'h0, 8'h40, 32'h0);
    check("config reset", rd, 32'h0);
    apb(1'h1, 8'h44, 32'hffff_0102);
    apb(1'h0, 8'h44, 32'h0);
    check("mode readback", rd, 32'h0000_0102);
    apb(1'h0, 8'h4c, 32'h0);
    check("unmapped read", {er, rd}, {1'h1, 32'h0});
    $display("test regs done");
  endtask
  task automatic t_mask32;
    apb(1'h1, 8'h44, 32'h0);
    apb(1'h1, 8'h00, pk(11'h123, 18'h15555, 1'h1));
    apb(1'h1, 8'h04, 32'h0000_ffff);
    apb(1'h1, 8'h40, 32'h7);
    fr(11'h123, 18'h15aa5, 1'h1, 3, 1'h1, 6'h00);
    check("stored id", store_id, pk(11'h123, 18'h15aa5, 1'h1));
    check("stored data", store_data, {16'h5aa5, {3{16'h0123}}});
    check("stored stamp", {store_dlc, store_stamp}, 20'h80123);
    fr(11'h124, 18'h15aa5, 1'h1, 3, 1'h0, 6'h00);
    $display("test mask32 done");
  endtask
  task automatic t_list;
    p = pk(11'h2a5, 18'h0, 1'h0);
    apb(1'h1, 8'h40, 32'h0);
    apb(1'h1, 8'h04, 32'h0);
    apb(1'h1, 8'h08, {p[15:0], 16'h0000});
    apb(1'h1, 8'h44, 32'h0202);
    apb(1'h1, 8'h40, 32'h67);
    fr(11'h2a5, 18'h0, 1'h0, 2, 1'h1, 6'h02);
    fr(11'h111, 18'h0, 1'h0, 3, 1'h1, 6'h00);
    $display("test list done");
  endtask
  task automatic t_cover;
    apb(1'h1, 8'h40, 32'h0);
    apb(1'h1, 8'h44, 32'h0);
    apb(1'h1, 8'h00, 32'hffaa_ff54);
    apb(1'h1, 8'h04, 32'hffaa_ffaa);
    apb(1'h1, 8'h08, {16'hffff, p[15:0]});
    apb(1'h1, 8'h0c, 32'hffff_aaaa);
    apb(1'h1, 8'h40, 32'h64);
    fr(11'h2a5, 18'h0, 1'h0, 3, 1'h1, 6'h04);
    fr(11'h2a0, 18'h3ffff, 1'h1, 3, 1'h1, 6'h00);
    apb(1'h1, 8'h40, 32'h0);
    apb(1'h1, 8'h44, 32'h1);
    apb(1'h1, 8'h40, 32'h64);
    fr(11'h2a5, 18'h0, 1'h0, 2, 1'h1, 6'h00);
    fr(11'h7f8, 18'h0, 1'h0, 2, 1'h1, 6'h01);
    apb(1'h1, 8'h40, 32'h0);
    apb(1'h1, 8'h40, 32'h65);
    fr(11'h550, 18'h0, 1'h0, 3, 1'h1, 6'h02);
    apb(1'h1, 8'h40, 32'h60);
    fr(11'h550, 18'h0, 1'h0, 3, 1'h0, 6'h00);
    apb(1'h0, 8'h0c, 32'h0);
    check("filter readback", {er, rd}, {1'h0, 32'hffff_aaaa});
    apb(1'h0, 8'h48, 32'h0);
    check("status after drop", {er, rd}, {1'h0, 32'h0008_0002});
    $display("test cover done");
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
    {fails, n_checks, cyc} = 96'h0;
    repeat (20) @(posedge pclk);
    presetn <= 1'h1;
    t_regs;
    t_mask32;
    t_list;
    t_cover;
    final_report;
  end
endmodule // tb_top
`default_nettype wire
